// File: pkg/charger_flag_pkg.sv
package charger_flag_pkg;
  // Register byte addresses on the host read port
  localparam logic [7:0] THERMAL_STATUS_ADDR = 8'h16;
  localparam logic [7:0] SUPPLY_STATUS_ADDR = 8'h17;
  localparam logic [7:0] PROTECT_FLAGS_ADDR = 8'h18;
  localparam logic [7:0] CURRENT_FLAGS_ADDR = 8'h19;
  localparam logic [7:0] PRESENCE_FLAGS_ADDR = 8'h1a;
  // Every register in the bank resets to this, and unmapped reads return it
  localparam logic [7:0] REG_RESET = 8'h00;
  // Supply status field positions; the other bits are reserved
  localparam int REGULATOR_OK_BIT = 7;
  localparam int SWITCHER_BIT = 6;
  localparam int ERROR_HIGH_BIT = 4;
  // Thermal, measurement and watchdog conditions, bit 7 down to bit 0
  typedef struct packed {
    logic conv_done;
    logic soft_start_timeout;
    logic thermistor_near_limit;
    logic connector_thermistor_fault;
    logic battery_thermistor_fault;
    logic junction_overheat_fault;
    logic junction_heat_alarm;
    logic host_link_watchdog;
  } thermal_cond_t;
  // Supply and converter conditions
  typedef struct packed {
    logic internal_regulator_ok;
    logic switcher_running;
    logic bus_voltage_error_high;
  } supply_cond_t;
  // Battery and input protection conditions, bit 7 down to bit 0
  typedef struct packed {
    logic battery_overvoltage;
    logic battery_overvoltage_alarm;
    logic output_overvoltage;
    logic battery_overcurrent;
    logic battery_overcurrent_alarm;
    logic battery_undercurrent_alarm;
    logic input_overvoltage;
    logic input_overvoltage_alarm;
  } protect_cond_t;
  // Input current conditions; they land on bits 7..4 and 2
  typedef struct packed {
    logic input_overcurrent;
    logic input_overcurrent_alarm;
    logic input_undercurrent;
    logic input_reverse_current;
    logic flying_cap_shorted;
  } current_cond_t;
  // Presence and configuration conditions, bit 7 down to bit 0
  typedef struct packed {
    logic source_one_overvoltage;
    logic source_two_overvoltage;
    logic output_detected;
    logic source_one_detected;
    logic source_two_detected;
    logic input_rail_detected;
    logic blocking_fet_pair_one_fitted;
    logic blocking_fet_pair_two_fitted;
  } presence_cond_t;
endpackage : charger_flag_pkg

// File: hw/charger_status_flag_bank.sv
// Function
// (RULE1) One-shot mode: bit 7 shows conversion complete
// (RULE2) Continuous mode: conversion bit always reads zero
// (RULE3) Bit 6 shows soft-start timeout
// (RULE4) Bit 5 shows thermistor near limit
// (RULE5) Bits 4, 3 show thermistor faults live
// (RULE6) Bits 2, 1 show junction fault, alarm
// (RULE7) Bit 0 shows host link watchdog expired
// (RULE8) Supply bit 7 shows regulator good
// (RULE9) Supply bit 6 shows switcher running
// (RULE10) Supply bit 4 error high; others zero
// (RULE11) Protection flags latch on condition change
// (RULE12) Current flags latch on change; reserved zero
// (RULE13) Presence flags latch on condition change
// (RULE14) All registers read-only, reset to zero
// (RULE15) Unmasked set flag raises interrupt output
// (RULE16) Reading a flag register clears it
// (RULE17) Host reads flags after interrupt, never writes

// Two-flop synchroniser for a group of condition pins
module cond_sync #(
  parameter int W = 8
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [W-1:0] D_IN,
  output logic [W-1:0] Q_OUT
);
  logic [W-1:0] meta; // First stage, read only by the second

  // Both stages clear with the bank so no change is seen at release
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      meta <= '0;
      Q_OUT <= '0;
    end else begin
      meta <= D_IN;
      Q_OUT <= meta;
    end
  end
endmodule : cond_sync

module charger_status_flag_bank (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire charger_flag_pkg::thermal_cond_t THERMAL_COND_IN,
  input wire charger_flag_pkg::supply_cond_t SUPPLY_COND_IN,
  input wire charger_flag_pkg::protect_cond_t PROTECT_COND_IN,
  input wire charger_flag_pkg::current_cond_t CURRENT_COND_IN,
  input wire charger_flag_pkg::presence_cond_t PRESENCE_COND_IN,
  input wire logic ADC_CONTINUOUS_IN,
  input wire logic [7:0] MASK_PROTECT_IN,
  input wire logic [7:0] MASK_CURRENT_IN,
  input wire logic [7:0] MASK_PRESENCE_IN,
  input wire logic RD_STB_IN,
  input wire logic [7:0] RD_ADDR_IN,
  output logic [7:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  output logic INT_OUT
);
  import charger_flag_pkg::*;

  thermal_cond_t th_s; // Synchronised conditions
  supply_cond_t sup_s;
  protect_cond_t prot_s;
  current_cond_t cur_s;
  presence_cond_t pres_s;
  logic [7:0] prot_prev; // Last cycle's conditions, for change detection
  logic [7:0] cur_prev;
  logic [7:0] pres_prev;
  logic [7:0] prot_flag; // Sticky change flags
  logic [7:0] cur_flag;
  logic [7:0] pres_flag;
  logic [7:0] cur_word; // Current conditions placed at their bit positions
  logic [7:0] change_prot;
  logic [7:0] change_cur;
  logic [7:0] change_pres;
  logic [7:0] next_prot_flag;
  logic [7:0] next_cur_flag;
  logic [7:0] next_pres_flag;
  logic [7:0] thermal_word;
  logic [7:0] supply_word;
  logic [7:0] rd_word;
  logic rd_thermal;
  logic rd_supply;
  logic rd_prot;
  logic rd_cur;
  logic rd_pres;
  logic irq_pending;

  // Analog monitors are asynchronous to the core clock, so every group is synchronised
  cond_sync #(.W($bits(thermal_cond_t))) u_sync_th (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .D_IN(THERMAL_COND_IN),
    .Q_OUT(th_s)
  );
  cond_sync #(.W($bits(supply_cond_t))) u_sync_sup (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .D_IN(SUPPLY_COND_IN),
    .Q_OUT(sup_s)
  );
  cond_sync #(.W($bits(protect_cond_t))) u_sync_prot (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .D_IN(PROTECT_COND_IN),
    .Q_OUT(prot_s)
  );
  cond_sync #(.W($bits(current_cond_t))) u_sync_cur (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .D_IN(CURRENT_COND_IN),
    .Q_OUT(cur_s)
  );
  cond_sync #(.W($bits(presence_cond_t))) u_sync_pres (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .D_IN(PRESENCE_COND_IN),
    .Q_OUT(pres_s)
  );

  // Address decode; there is no write path, the bank is read-only
  assign rd_thermal = RD_STB_IN && (RD_ADDR_IN == THERMAL_STATUS_ADDR); // RULE14
  assign rd_supply = RD_STB_IN && (RD_ADDR_IN == SUPPLY_STATUS_ADDR);
  assign rd_prot = RD_STB_IN && (RD_ADDR_IN == PROTECT_FLAGS_ADDR);
  assign rd_cur = RD_STB_IN && (RD_ADDR_IN == CURRENT_FLAGS_ADDR);
  assign rd_pres = RD_STB_IN && (RD_ADDR_IN == PRESENCE_FLAGS_ADDR);

  // Live thermal status; the done bit is forced low in continuous mode
  assign thermal_word = {th_s.conv_done & ~ADC_CONTINUOUS_IN, th_s[6:0]}; // RULE1 RULE2
  // Bits 6..0 pass straight through from the monitors
  // RULE3 RULE4 RULE5 RULE6 RULE7

  // Supply status; reserved bits stay zero
  always_comb begin
    supply_word = REG_RESET; // RULE10
    supply_word[REGULATOR_OK_BIT] = sup_s.internal_regulator_ok; // RULE8
    supply_word[SWITCHER_BIT] = sup_s.switcher_running; // RULE9
    supply_word[ERROR_HIGH_BIT] = sup_s.bus_voltage_error_high; // RULE10
  end

  // Current flags skip bits 3, 1 and 0, so those can never set
  assign cur_word = {cur_s[4:1], 1'b0, cur_s[0], 2'b00}; // RULE12

  // A change in either direction counts as an event
  assign change_prot = prot_s ^ prot_prev; // RULE11
  assign change_cur = cur_word ^ cur_prev; // RULE12
  assign change_pres = pres_s ^ pres_prev; // RULE13

  // Read clears, but a change in the same cycle wins so no event is lost
  assign next_prot_flag = (prot_flag & ~{8{rd_prot}}) | change_prot; // RULE11 RULE16
  assign next_cur_flag = (cur_flag & ~{8{rd_cur}}) | change_cur; // RULE12 RULE16
  assign next_pres_flag = (pres_flag & ~{8{rd_pres}}) | change_pres; // RULE13 RULE16

  // Read data select; unmapped addresses answer zero
  assign rd_word = rd_thermal ? thermal_word :
                   rd_supply ? supply_word :
                   rd_prot ? prot_flag :
                   rd_cur ? cur_flag :
                   rd_pres ? pres_flag : REG_RESET;

  // Mask bit of one keeps the flag off the interrupt line
  assign irq_pending = |(prot_flag & ~MASK_PROTECT_IN) | // RULE15
                       |(cur_flag & ~MASK_CURRENT_IN) |
                       |(pres_flag & ~MASK_PRESENCE_IN);

  // Previous conditions and sticky flags
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      prot_prev <= REG_RESET;
      cur_prev <= REG_RESET;
      pres_prev <= REG_RESET;
      prot_flag <= REG_RESET; // RULE14
      cur_flag <= REG_RESET;
      pres_flag <= REG_RESET;
    end else begin
      prot_prev <= prot_s;
      cur_prev <= cur_word;
      pres_prev <= pres_s;
      prot_flag <= next_prot_flag;
      cur_flag <= next_cur_flag;
      pres_flag <= next_pres_flag;
    end
  end

  // Registered read answer and interrupt, one cycle after their cause
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= REG_RESET;
      RD_VALID_OUT <= 1'b0;
      INT_OUT <= 1'b0;
    end else begin
      RD_DATA_OUT <= rd_word;
      RD_VALID_OUT <= RD_STB_IN;
      INT_OUT <= irq_pending; // RULE15
    end
  end

  // Continuous mode never reports a finished conversion
  conv_cont_zero_a : assert property ( // RULE2
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    rd_thermal && ADC_CONTINUOUS_IN |=> RD_VALID_OUT && !RD_DATA_OUT[7])
    else $error("conversion bit set in continuous mode");

  // One-shot mode shows the done condition as sampled
  conv_oneshot_a : assert property ( // RULE1
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    rd_thermal && !ADC_CONTINUOUS_IN |=> RD_DATA_OUT[7] == $past(th_s.conv_done))
    else $error("conversion bit wrong in one-shot mode");

  // Thermal and watchdog bits follow the synchronised conditions
  thermal_live_a : assert property ( // RULE3 RULE4 RULE5 RULE6 RULE7
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    rd_thermal |=> RD_DATA_OUT[6:0] == $past(th_s[6:0]))
    else $error("thermal status bits wrong");

  // Supply word layout with reserved zeros
  supply_layout_a : assert property ( // RULE8 RULE9 RULE10
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    rd_supply |=> RD_DATA_OUT == {$past(sup_s.internal_regulator_ok),
      $past(sup_s.switcher_running), 1'b0, $past(sup_s.bus_voltage_error_high), 4'h0})
    else $error("supply status word wrong");

  // A protection condition that toggles sets its flag next cycle
  prot_change_set_a : assert property ( // RULE11
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    change_prot != 8'h00
    |=> (prot_flag & $past(change_prot)) == $past(change_prot))
    else $error("protection change did not set flag");

  // A presence flag holds while nothing changes and nobody reads
  pres_flag_hold_a : assert property ( // RULE13
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    !rd_pres && change_pres == 8'h00 |=> $stable(pres_flag))
    else $error("presence flag moved without cause");

  // Reserved current flag bits never set
  cur_reserved_a : assert property ( // RULE12
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    cur_flag[3] == 1'b0 && cur_flag[1:0] == 2'b00)
    else $error("reserved current flag bit set");

  // Reading returns the flags and then clears them
  read_clear_a : assert property ( // RULE16
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    rd_pres && change_pres == 8'h00
    |=> pres_flag == 8'h00 && RD_DATA_OUT == $past(pres_flag))
    else $error("presence read did not clear");

  // Interrupt follows the unmasked flags by one cycle
  irq_follow_a : assert property ( // RULE15
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    ##1 INT_OUT == $past(|(prot_flag & ~MASK_PROTECT_IN) |
      |(cur_flag & ~MASK_CURRENT_IN) | |(pres_flag & ~MASK_PRESENCE_IN)))
    else $error("interrupt does not match unmasked flags");

  // Everything leaves reset cleared
  reset_clear_a : assert property ( // RULE14
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $rose(RST_N_IN) |-> prot_flag == 8'h00 && cur_flag == 8'h00 &&
      pres_flag == 8'h00 && !INT_OUT && RD_DATA_OUT == 8'h00)
    else $error("bank not cleared by reset");

  // Unmapped reads answer zero
  unmapped_zero_a : assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    RD_STB_IN && !(rd_thermal || rd_supply || rd_prot || rd_cur || rd_pres)
    |=> RD_DATA_OUT == 8'h00)
    else $error("unmapped read not zero");
endmodule : charger_status_flag_bank

// File: sim/host_reader.sv
// Host side of the read port: one byte read at a time, nothing else
module host_reader (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic rd_stb_out,
  output logic [7:0] rd_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: no strobe, address parked off the map
  initial begin
    rd_stb_out = 1'b0;
    rd_addr_out = 8'hff;
  end

  // Read only, never a write; data taken with the one-cycle valid pulse
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_in);
    rd_stb_out = 1'b1;
    rd_addr_out = addr;
    @(negedge clk_in);
    rd_stb_out = 1'b0;
    // Released address shows its inverse so a stale value cannot look right
    rd_addr_out = ~addr;
    // Answer stands one cycle only, so a missing pulse gives unknown data
    data = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
  endtask : read
endmodule : host_reader

// File: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import charger_flag_pkg::*;

  logic clk;
  logic rst_n;
  thermal_cond_t thermal;
  supply_cond_t supply;
  protect_cond_t protect;
  current_cond_t current;
  presence_cond_t presence;
  logic adc_cont;
  logic [7:0] mask_p, mask_c, mask_s;
  logic stb;
  logic [7:0] addr;
  logic [7:0] rdata;
  logic valid;
  logic irq;
  int err_total;
  int cmp_count;

  charger_status_flag_bank DUT (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .THERMAL_COND_IN(thermal),
    .SUPPLY_COND_IN(supply), .PROTECT_COND_IN(protect), .CURRENT_COND_IN(current),
    .PRESENCE_COND_IN(presence), .ADC_CONTINUOUS_IN(adc_cont),
    .MASK_PROTECT_IN(mask_p), .MASK_CURRENT_IN(mask_c), .MASK_PRESENCE_IN(mask_s),
    .RD_STB_IN(stb), .RD_ADDR_IN(addr), .RD_DATA_OUT(rdata),
    .RD_VALID_OUT(valid), .INT_OUT(irq));

  host_reader host (.clk_in(clk), .rd_data_in(rdata), .rd_valid_in(valid),
    .rd_stb_out(stb), .rd_addr_out(addr));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read(a, d);
    check(d, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Fresh bank: every place reads zero, unmapped ones too
  task automatic t_reset();
    logic [7:0] addrs [8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h00, 8'hff};
    foreach (addrs[k]) rd_chk(addrs[k], REG_RESET);
    check({7'h00, irq}, 8'h00);
  endtask : t_reset

  // Walk one live thermal bit in both measurement modes
  task automatic t_thermal();
    for (int i = 0; i < 8; i++) begin
      thermal = thermal_cond_t'(8'h01 << i);
      adc_cont = 1'b0;
      idle(4);
      rd_chk(THERMAL_STATUS_ADDR, 8'h01 << i);
      adc_cont = 1'b1;
      rd_chk(THERMAL_STATUS_ADDR, (8'h01 << i) & 8'h7f);
    end
    thermal = '0;
  endtask : t_thermal

  // All supply combinations; reserved bits must stay zero
  task automatic t_supply();
    for (int v = 0; v < 8; v++) begin
      supply = supply_cond_t'(v[2:0]);
      idle(4);
      rd_chk(SUPPLY_STATUS_ADDR, {v[2], v[1], 1'b0, v[0], 4'h0});
    end
  endtask : t_supply

  // Rising change on each condition: flag, interrupt, clear on read
  task automatic t_flags();
    logic [7:0] bitv;
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 8; i++) begin
        if (r == 1 && i > 4) continue;
        case (r)
          0: protect[i] = ~protect[i];
          1: current[i] = ~current[i];
          default: presence[i] = ~presence[i];
        endcase
        // Current conditions skip the reserved bit 3
        bitv = (r != 1) ? 8'h01 << i : (i == 0) ? 8'h04 : 8'h01 << (i + 3);
        idle(5);
        check({7'h00, irq}, 8'h01);
        rd_chk(PROTECT_FLAGS_ADDR + 8'(r), bitv);
        rd_chk(PROTECT_FLAGS_ADDR + 8'(r), 8'h00);
        check({7'h00, irq}, 8'h00);
      end
    end
  endtask : t_flags

  // Falling changes while masked: flags latch but interrupt stays low
  task automatic t_mask();
    mask_p = 8'hff;
    mask_c = 8'hff;
    mask_s = 8'hff;
    protect = '0;
    current = '0;
    presence = '0;
    idle(6);
    check({7'h00, irq}, 8'h00);
    mask_p = 8'h00;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd_chk(PROTECT_FLAGS_ADDR, 8'hff);
    // Interrupt is registered, so it drops one cycle after the clearing read
    idle(1);
    check({7'h00, irq}, 8'h00);
    mask_c = 8'hfb;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd_chk(CURRENT_FLAGS_ADDR, 8'hf4);
    rd_chk(PRESENCE_FLAGS_ADDR, 8'hff);
    idle(2);
    check({7'h00, irq}, 8'h00);
  endtask : t_mask

  // Mid-run reset drops latched flags and the interrupt; protection pins go quiet while it is held
  task automatic t_midreset();
    protect = 8'h3c;
    idle(5);
    check({7'h00, irq}, 8'h01);
    rst_n = 1'b0;
    protect = '0;
    idle(2);
    rst_n = 1'b1;
    check({7'h00, irq}, 8'h00);
    rd_chk(PROTECT_FLAGS_ADDR, REG_RESET);
  endtask : t_midreset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Main sequence: inputs quiet through a 16-cycle reset
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    thermal = '0;
    supply = '0;
    protect = '0;
    current = '0;
    presence = '0;
    adc_cont = 1'b0;
    mask_p = 8'h00;
    mask_c = 8'h00;
    mask_s = 8'h00;
    idle(16);
    rst_n = 1'b1;
    t_reset();
    t_thermal();
    t_supply();
    t_flags();
    t_mask();
    t_midreset();
    end_of_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule : tb
